// >>> pkg/ssb_pkg.sv
package ssb_pkg;
  // Data bus: four 9-bit byte lanes
  localparam int ADDR_W      = 20;
  localparam int LANES       = 4;
  localparam int LANE_W      = 9;
  localparam int DATA_W      = LANES * LANE_W;
  localparam int BURST_W     = 2;
  localparam int DEPTH       = 256;
  localparam int MEM_AW      = 8;
  // Sleep entry and wake-up delays in cycles
  localparam int SLEEP_ENTER_CYC = 2;
  localparam int SLEEP_WAKE_CYC  = 2;
  localparam logic [1:0] CNT_ZERO = 2'h0;
  localparam logic [1:0] CNT_ONE  = 2'h1;

  typedef enum logic [1:0]
  {
    SSB_IDLE  = 2'b00,
    SSB_READ  = 2'b01,
    SSB_WRITE = 2'b10
  } ssb_dir_type;
endpackage

// >>> pkg/ssb_burst_if.sv
`timescale 1ns/100ps
interface ssb_burst_if;
  import ssb_pkg::*;
  logic               load;
  logic               advance;
  logic               interleave;
  logic [BURST_W-1:0] start;
  logic [BURST_W-1:0] addr_lo;

  modport ctrl (output load, output advance, output interleave, output start, input addr_lo);
  modport cnt  (input load, input advance, input interleave, input start, output addr_lo);
endinterface

// >>> design/ssb_burst_counter.sv
`timescale 1ns/100ps
module ssb_burst_counter
  import ssb_pkg::*;
(
  input  wire logic  clock_i,
  input  wire logic  nrst_i,
  input  wire logic  cke_i,
  ssb_burst_if.cnt   bif
);
  // ==========================================
  // Burst count, wraps to start on fifth beat
  // ==========================================
  logic [BURST_W-1:0] count_reg;
  logic [BURST_W-1:0] count_next;
  logic [BURST_W-1:0] start_reg;
  logic [BURST_W-1:0] start_next;
  logic [BURST_W-1:0] linear_addr;
  logic [BURST_W-1:0] inter_addr;

  assign count_next  = bif.load ? CNT_ZERO : (bif.advance ? count_reg + CNT_ONE : count_reg);
  assign start_next  = bif.load ? bif.start : start_reg;
  assign linear_addr = start_reg + count_reg;
  assign inter_addr  = start_reg ^ count_reg;
  assign bif.addr_lo = bif.interleave ? inter_addr : linear_addr;

  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      count_reg <= CNT_ZERO;
      start_reg <= CNT_ZERO;
    end
    else if (cke_i)
    begin
      count_reg <= count_next;
      start_reg <= start_next;
    end
  end
endmodule

// >>> design/ssb_sram_core.sv
`timescale 1ns/100ps
// Overview of operation
// - Begin read on gated edge with load low, strobe high, all selects active.
// - Begin write on gated edge with load and strobe low, all selects active.
// - Load high continues burst, ignoring strobe and selects, keeping direction.
// - Write with all lanes high writes nothing and leaves bus floating.
// - Read with output enable high is a no-op, address still moves.
// - Drivers turn off during write cycles whatever the output enable.
// - Load low with any select inactive is a power-down deselect.
// - Gate high holds all state while awake except synchronisers and sleep sequencing; stalled pipelined read keeps driving.
// - Bus floats from reset until a read enables the drivers.
// - Two-bit counter loaded at start, advances on every continue cycle.
// - Counter returns to loaded value on fifth cycle and repeats.
// - Linear order adds the count to the start value modulo four.
// - Interleaved order XORs the count with the start value.
// - Flow-through strap low gives flow-through, high gives pipelined timing.
// - Sleep request high enters sleep two cycles later, state preserved.
// - Sleep request low resumes operation after two wake-up cycles.
// - Asleep the device is deselected, ignores inputs, floats outputs.
// - Pipelined: write data on third edge, read data two cycles later.
// - Flow-through: write data on second edge, read data one cycle later.
// - Low byte lane enable writes its byte; high lanes stay unchanged.
module ssb_sram_core
  import ssb_pkg::*;
(
  input  wire logic              clock_i,
  input  wire logic              nrst_i,
  input  wire logic              cke_i,
  input  wire logic              clock_gate_n_i,
  input  wire logic              address_load_n_i,
  input  wire logic              store_strobe_n_i,
  input  wire logic [LANES-1:0]  byte_lane_n_i,
  input  wire logic              select_one_n_i,
  input  wire logic              select_two_i,
  input  wire logic              select_three_n_i,
  input  wire logic              output_enable_n_i,
  input  wire logic              sleep_request_i,
  input  wire logic              flow_through_n_i,
  input  wire logic              linear_order_n_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] dq_i,
  output logic      [DATA_W-1:0] dq_o,
  output logic      [DATA_W-1:0] dq_oe_n_o,
  output logic                   asleep_o
);
  // ==========================================
  // Synchronisers for asynchronous pins
  // ==========================================
  logic sleep_s1_reg;
  logic sleep_s2_reg;
  logic oe_s1_reg;
  logic oe_s2_reg;

  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      sleep_s1_reg <= 1'b0;
      sleep_s2_reg <= 1'b0;
      oe_s1_reg    <= 1'b1;
      oe_s2_reg    <= 1'b1;
    end
    else if (cke_i)
    begin
      sleep_s1_reg <= sleep_request_i;
      sleep_s2_reg <= sleep_s1_reg;
      oe_s1_reg    <= output_enable_n_i;
      oe_s2_reg    <= oe_s1_reg;
    end
  end

  // ==========================================
  // Sleep sequencing
  // ==========================================
  logic [1:0] sleep_cnt_reg;
  logic [1:0] sleep_cnt_next;
  logic       asleep_reg;
  logic       asleep_next;
  logic       waking_reg;
  logic       waking_next;
  logic       sleep_edge;

  // Counts synchronised level; while asleep, state is frozen except the read drive flags, which clear
  assign sleep_edge = sleep_s2_reg != asleep_reg;
  assign sleep_cnt_next = !sleep_edge ? 2'h0
                        : (sleep_cnt_reg == 2'(SLEEP_ENTER_CYC - 1) ? 2'h0
                        : sleep_cnt_reg + 2'h1);
  assign asleep_next = (sleep_edge && sleep_cnt_reg == 2'(SLEEP_ENTER_CYC - 1))
                     ? sleep_s2_reg : asleep_reg;
  assign waking_next = sleep_edge && asleep_reg;

  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      sleep_cnt_reg <= 2'h0;
      asleep_reg    <= 1'b0;
      waking_reg    <= 1'b0;
    end
    else if (cke_i)
    begin
      sleep_cnt_reg <= sleep_cnt_next;
      asleep_reg    <= asleep_next;
      waking_reg    <= waking_next;
    end
  end

  // ==========================================
  // Command decode
  // ==========================================
  logic        active;
  logic        selected;
  logic        any_lane;
  logic        start_read;
  logic        start_write;
  logic        deselect;
  logic        cont;
  ssb_dir_type dir_reg;
  ssb_dir_type dir_next;
  ssb_dir_type beat_dir;

  assign active      = cke_i && !clock_gate_n_i && !asleep_reg;
  assign selected    = !select_one_n_i && select_two_i && !select_three_n_i;
  assign any_lane    = byte_lane_n_i != {LANES{1'b1}};
  assign start_read  = active && !address_load_n_i && selected && store_strobe_n_i;
  assign start_write = active && !address_load_n_i && selected && !store_strobe_n_i;
  assign deselect    = active && !address_load_n_i && !selected;
  assign cont        = active && address_load_n_i;
  assign dir_next    = start_read ? SSB_READ : (start_write ? SSB_WRITE
                     : (deselect ? SSB_IDLE : dir_reg));
  assign beat_dir    = (start_read || start_write) ? dir_next
                     : (cont ? dir_reg : SSB_IDLE);

  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
      dir_reg <= SSB_IDLE;
    else if (active)
      dir_reg <= dir_next;
  end

  // ==========================================
  // Burst address
  // ==========================================
  ssb_burst_if bif ();
  logic [ADDR_W-1:0]  base_reg;
  logic [ADDR_W-1:0]  beat_addr;
  logic [MEM_AW-1:0]  mem_idx;

  assign bif.load       = start_read || start_write;
  assign bif.advance    = cont;
  assign bif.interleave = linear_order_n_i;
  assign bif.start      = addr_i[BURST_W-1:0];

  ssb_burst_counter u_cnt
  (
    .clock_i (clock_i),
    .nrst_i  (nrst_i),
    .cke_i   (active),
    .bif     (bif)
  );

  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
      base_reg <= '0;
    else if (active && bif.load)
      base_reg <= addr_i;
  end

  // Counter holds the current beat one edge after load/advance
  logic              beat_valid_reg;
  ssb_dir_type       beat_dir_reg;
  logic [LANES-1:0]  beat_lane_reg;
  logic              beat_oe_n_reg;

  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      beat_valid_reg <= 1'b0;
      beat_dir_reg   <= SSB_IDLE;
      beat_lane_reg  <= {LANES{1'b1}};
      beat_oe_n_reg  <= 1'b1;
    end
    else if (cke_i && !asleep_reg && !clock_gate_n_i)
    begin
      beat_valid_reg <= beat_dir != SSB_IDLE;
      beat_dir_reg   <= beat_dir;
      beat_lane_reg  <= byte_lane_n_i;
      beat_oe_n_reg  <= oe_s2_reg;
    end
  end

  assign beat_addr = {base_reg[ADDR_W-1:BURST_W], bif.addr_lo};
  assign mem_idx   = beat_addr[MEM_AW-1:0];

  // ==========================================
  // Array and write pipeline
  // ==========================================
  logic [DATA_W-1:0] mem [DEPTH];
  logic [MEM_AW-1:0] wr_addr_reg;
  logic [LANES-1:0]  wr_lane_reg;
  logic              wr_pend_reg;
  logic              wr_now;
  logic [DATA_W-1:0] rd_word;

  // Pipelined: write data one edge after beat stage; flow-through: at beat stage
  // Stalled or frozen edges must not write, or a stalled beat lands twice
  assign wr_now  = active && (flow_through_n_i ? wr_pend_reg
                 : (beat_valid_reg && beat_dir_reg == SSB_WRITE));
  assign rd_word = mem[mem_idx];

  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
      wr_lane_reg <= {LANES{1'b1}};
    end
    else if (active)
    begin
      wr_pend_reg <= beat_valid_reg && beat_dir_reg == SSB_WRITE;
      wr_addr_reg <= mem_idx;
      wr_lane_reg <= beat_lane_reg;
    end
  end

  logic [MEM_AW-1:0] wr_idx;
  logic [LANES-1:0]  wr_lanes;

  assign wr_idx   = flow_through_n_i ? wr_addr_reg : mem_idx;
  assign wr_lanes = flow_through_n_i ? wr_lane_reg : beat_lane_reg;

  always_ff @(posedge clock_i)
  begin
    if (wr_now)
    begin
      for (int i = 0; i < LANES; i++)
        if (!wr_lanes[i])
          mem[wr_idx][i*LANE_W +: LANE_W] <= dq_i[i*LANE_W +: LANE_W];
    end
  end

  // ==========================================
  // Read output stage
  // ==========================================
  logic              rd_beat;
  logic              drive_next;
  logic [DATA_W-1:0] dq_next;
  logic              drive_reg;
  logic [DATA_W-1:0] dq_reg;
  logic              pipe_drive_reg;
  logic [DATA_W-1:0] pipe_data_reg;
  logic              out_run;

  assign rd_beat = beat_valid_reg && beat_dir_reg == SSB_READ && !beat_oe_n_reg;
  // Output stage holds on a stall so a pipelined read keeps its word
  assign out_run = cke_i && (!clock_gate_n_i || asleep_reg);

  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      pipe_drive_reg <= 1'b0;
      pipe_data_reg  <= '0;
    end
    else if (cke_i && asleep_reg)
      pipe_drive_reg <= 1'b0;
    else if (active)
    begin
      pipe_drive_reg <= rd_beat;
      pipe_data_reg  <= rd_word;
    end
  end

  // Flow-through drives the beat's data one stage earlier than pipelined
  assign drive_next = !asleep_next && !oe_s2_reg
                   && (flow_through_n_i ? pipe_drive_reg : rd_beat);
  assign dq_next    = flow_through_n_i ? pipe_data_reg : rd_word;

  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      drive_reg <= 1'b0;
      dq_reg    <= '0;
    end
    else if (out_run)
    begin
      drive_reg <= drive_next;
      dq_reg    <= dq_next;
    end
  end

  // Synchronised output enable adds latency; the host sees it two edges late
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      dq_o      <= '0;
      dq_oe_n_o <= {DATA_W{1'b1}};
      asleep_o  <= 1'b0;
    end
    else if (cke_i)
    begin
      if (out_run)
        dq_o    <= dq_reg;
      dq_oe_n_o <= {DATA_W{!(drive_reg && !oe_s2_reg && !asleep_reg)}};
      asleep_o  <= asleep_reg || waking_reg;
    end
  end
endmodule

// >>> dv/ssb_sram_core_props.sv
`timescale 1ns/100ps
module ssb_sram_core_props
  import ssb_pkg::*;
(
  input wire logic              clock_i,
  input wire logic              nrst_i,
  input wire logic              cke_i,
  input wire logic              clock_gate_n_i,
  input wire logic              address_load_n_i,
  input wire logic              store_strobe_n_i,
  input wire logic [LANES-1:0]  byte_lane_n_i,
  input wire logic              select_one_n_i,
  input wire logic              select_two_i,
  input wire logic              select_three_n_i,
  input wire logic              output_enable_n_i,
  input wire logic              sleep_request_i,
  input wire logic              flow_through_n_i,
  input wire logic              linear_order_n_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] dq_i,
  input wire logic [DATA_W-1:0] dq_o,
  input wire logic [DATA_W-1:0] dq_oe_n_o,
  input wire logic              asleep_o
);
  // ====================
  // Command decode
  wire sel_w   = !select_one_n_i && select_two_i && !select_three_n_i;
  wire load_w  = cke_i && !clock_gate_n_i && !address_load_n_i;
  wire cont_w  = cke_i && !clock_gate_n_i && address_load_n_i;
  wire wr_w    = load_w && sel_w && !store_strobe_n_i;
  wire float_w = &dq_oe_n_o;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  property p_rst; $rose(nrst_i) |-> float_w; endproperty
  a_rst: assert property (p_rst) else $error("bus driven after reset");
  property p_wr; wr_w ##1 cont_w [*5] |-> float_w; endproperty
  a_wr: assert property (p_wr) else $error("bus driven in write burst");
  property p_desel; (load_w && !sel_w) [*5] |-> float_w; endproperty
  a_desel: assert property (p_desel) else $error("bus driven while deselected");
  property p_abort; (wr_w && &byte_lane_n_i) [*5] |-> float_w; endproperty
  a_abort: assert property (p_abort) else $error("bus driven on write abort");
  property p_oe; output_enable_n_i [*5] |-> float_w; endproperty
  a_oe: assert property (p_oe) else $error("bus driven with enable high");
  property p_slp; asleep_o |-> float_w; endproperty
  a_slp: assert property (p_slp) else $error("bus driven while asleep");
  property p_in; sleep_request_i [*6] |-> asleep_o; endproperty
  a_in: assert property (p_in) else $error("sleep not entered");
  property p_early; $rose(sleep_request_i) |=> !asleep_o; endproperty
  a_early: assert property (p_early) else $error("sleep entered early");
  property p_out; !sleep_request_i [*7] |-> !asleep_o; endproperty
  a_out: assert property (p_out) else $error("sleep not left");
  property p_wake; $fell(sleep_request_i) && asleep_o |=> asleep_o; endproperty
  a_wake: assert property (p_wake) else $error("wake without recovery");
  property p_stall; cke_i && clock_gate_n_i |=> $stable(dq_o); endproperty
  a_stall: assert property (p_stall) else $error("data moved in stall");
  c_wr: cover property (wr_w ##1 cont_w);
  c_rd: cover property (load_w && sel_w && store_strobe_n_i);
  c_slp: cover property (asleep_o);
endmodule

// >>> dv/ssb_host_model.sv
`timescale 1ns/100ps
module ssb_host_model
  import ssb_pkg::*;
(
  input  wire logic              clock_i,
  output logic                   gate_n_o,
  output logic                   load_n_o,
  output logic                   strobe_n_o,
  output logic      [LANES-1:0]  lane_n_o,
  output logic      [2:0]        sel_o,
  output logic      [ADDR_W-1:0] addr_o,
  output logic      [DATA_W-1:0] dq_o
);
  // ====================
  // Beat driver, write data two taken edges behind its command
  logic [DATA_W:0] pipe [2] = '{default: '0};
  initial
  begin
    {gate_n_o, load_n_o, strobe_n_o, lane_n_o, sel_o} = {7'h07, 3'b110};
    addr_o = '0;
    dq_o = '0;
  end
  task automatic beat(input logic g, l, s, dv, input logic [LANES-1:0] ln,
                      input logic [2:0] se, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d);
    @(negedge clock_i);
    {gate_n_o, load_n_o, strobe_n_o, lane_n_o, sel_o, addr_o} = {g, l, s, ln, se, a};
    // Stall keeps data; idle slots toggle so nothing stale passes
    if (!g)
    begin
      dq_o = pipe[1][DATA_W] ? pipe[1][DATA_W-1:0] : ~dq_o;
      pipe[1] = pipe[0];
      pipe[0] = {dv, d};
    end
  endtask
endmodule

// >>> dv/ssb_sram_core_tb_top.sv
`timescale 1ns/100ps
module ssb_sram_core_tb_top;
  import ssb_pkg::*;
  localparam logic [2:0] ON = 3'b010;
  logic              clock_i = 1'b0;
  logic              nrst_i = 1'b0;
  logic              oe_n = 1'b0;
  logic              sleep = 1'b0;
  logic              lin_n = 1'b0;
  logic              gate_n, ld_n, st_n, asleep_o;
  logic [LANES-1:0]  ln_n;
  logic [2:0]        sel;
  logic [ADDR_W-1:0] addr, base;
  logic [DATA_W-1:0] dq_i, dq_o, dq_oe_n_o;
  logic [DATA_W-1:0] mem [DEPTH];
  logic [DATA_W:0]   ex [8];
  logic [1:0]        k;
  ssb_dir_type       dir;
  int                err_count = 0;
  int                num_checks = 0;
  int                n = 0;
  always #2.5 clock_i = ~clock_i;
  ssb_sram_core i_dut (.clock_i(clock_i), .nrst_i(nrst_i), .cke_i(1'b1),
    .clock_gate_n_i(gate_n), .address_load_n_i(ld_n), .store_strobe_n_i(st_n),
    .byte_lane_n_i(ln_n), .select_one_n_i(sel[2]), .select_two_i(sel[1]),
    .select_three_n_i(sel[0]), .output_enable_n_i(oe_n), .sleep_request_i(sleep),
    .flow_through_n_i(1'b1), .linear_order_n_i(lin_n), .addr_i(addr), .dq_i(dq_i),
    .dq_o(dq_o), .dq_oe_n_o(dq_oe_n_o), .asleep_o(asleep_o));
  ssb_host_model i_host (.clock_i(clock_i), .gate_n_o(gate_n), .load_n_o(ld_n),
    .strobe_n_o(st_n), .lane_n_o(ln_n), .sel_o(sel), .addr_o(addr), .dq_o(dq_i));
  // ====================
  // Access tasks with reference array
  task automatic chk(input string nm, input logic [DATA_W-1:0] e, g);
    num_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic op(input logic l, s, input logic [LANES-1:0] ln, input logic [2:0] se,
                    input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [ADDR_W-1:0] ad;
    logic [DATA_W-1:0] m;
    logic [DATA_W:0]   e;
    if (!l)
    begin
      base = a;
      k = 2'h0;
      dir = (se != ON) ? SSB_IDLE : (s ? SSB_READ : SSB_WRITE);
    end
    else
      k = k + 2'h1;
    ad = {base[ADDR_W-1:2], lin_n ? base[1:0] ^ k : base[1:0] + k};
    m = mem[ad[MEM_AW-1:0]];
    for (int i = 0; i < LANES; i++)
      if (dir == SSB_WRITE && !ln[i]) m[i*LANE_W +: LANE_W] = d[i*LANE_W +: LANE_W];
    mem[ad[MEM_AW-1:0]] = m;
    ex[n % 8] = {dir == SSB_READ && !oe_n, m};
    i_host.beat(1'b0, l, s, dir == SSB_WRITE, ln, se, a, d);
    if (n >= 4)
    begin
      e = ex[(n - 4) % 8];
      chk("dq_oe_n", {DATA_W{!e[DATA_W]}}, dq_oe_n_o);
      if (e[DATA_W])
        chk("dq", e[DATA_W-1:0], dq_o);
    end
    n++;
  endtask
  task automatic idle(input int c);
    repeat (c) op(1'b0, 1'b1, 4'hf, 3'b110, '0, '0);
  endtask
  task automatic burst(input logic s, input logic [ADDR_W-1:0] a, input int c);
    for (int i = 0; i < c; i++)
    begin
      if (i == 2)
        i_host.beat(1'b1, 1'b1, 1'b1, 1'b0, 4'hf, ON, '0, '0);
      op(i != 0, s | (i != 0), 4'h0, i ? 3'b110 : ON, a, 36'h1_2345_6780 + i);
    end
    idle(4);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(negedge clock_i);
    nrst_i = 1'b1;
    chk("dq_oe_n", '1, dq_oe_n_o);
    burst(1'b0, 20'h00041, 4);
    op(1'b0, 1'b0, 4'he, ON, 20'h00042, 36'h0_0000_01ff);
    repeat (5) op(1'b0, 1'b0, 4'hf, ON, 20'h00043, '0);
    idle(1);
    op(1'b0, 1'b1, 4'hf, 3'b000, '0, '0);
    op(1'b0, 1'b1, 4'hf, 3'b011, '0, '0);
    op(1'b1, 1'b1, 4'hf, ON, '0, '0);
    idle(3);
    burst(1'b1, 20'h00041, 5);
    $display("linear burst test done");
    lin_n = 1'b1;
    burst(1'b0, 20'h00047, 4);
    burst(1'b1, 20'h00047, 4);
    $display("interleaved burst test done");
    oe_n = 1'b1;
    idle(4);
    burst(1'b1, 20'h00041, 2);
    oe_n = 1'b0;
    idle(4);
    $display("output enable test done");
    sleep = 1'b1;
    repeat (8) @(negedge clock_i);
    chk("asleep", DATA_W'(1), DATA_W'(asleep_o));
    sleep = 1'b0;
    repeat (8) @(negedge clock_i);
    chk("asleep", DATA_W'(0), DATA_W'(asleep_o));
    burst(1'b1, 20'h00047, 4);
    $display("sleep test done");
    finish_test;
  end
  initial
  begin
    // Tests need about 100 cycles
    #20000;
    err_count++;
    finish_test;
  end
endmodule
bind ssb_sram_core ssb_sram_core_props i_props (.*);
